// [include/bridge_consts.svh]
// Register offsets, field positions, reset values and address constants of the bridge
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH
`define REG_STATUS      8'h00
`define REG_ENABLE      8'h04
`define REG_RESET       8'h08
`define REG_INFO        8'h0c
`define REG_BIOS        8'h10
`define REG_KEY         8'h14
`define NUM_SRC         7
`define HARD_RST_BIT    0
`define INFO_DIMM_BIT   0
`define INFO_BUSY_BIT   1
`define INFO_GRANT_BIT  2
`define ENABLE_RESET    7'h00
`define HARD_RST_RESET  1'b1
`define BIOS_RESET      32'h00000000
`define VEC_TOP_TAG     12'hfff
`define LOW_TAG         12'h000
`define BIOS_TAG        15'h0007
`define BIOS_PAD        15'h0000
`define DIMM_SETTLE     2'h3
`endif

// [include/bridge_pkg.sv]
// Types shared by the bridge interrupt and reset controller
package bridge_pkg;
    // One-hot states of the card-side bus master
    typedef enum logic [2:0] {
        MST_IDLE = 3'b001,
        MST_REQ  = 3'b010,
        MST_SEND = 3'b100
    } mst_state_t;

    // Card interrupt sources, one level each
    typedef struct packed {
        logic mouse;
        logic printer;
        logic message;
        logic sound;
        logic serialA;
        logic serialB;
        logic keyboard;
    } irq_src_t;

    // Address request from the card processor side
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } card_req_t;
endpackage : bridge_pkg

// [logic/bridge_interrupt_reset_ctrl.sv]
// Host-side interrupt gathering, card reset, BIOS remap and card-bus master of the bridge
//
// Register access over APB and the register addresses were decided locally.
`include "bridge_consts.svh"

// Behaviour
// - Card events reach host through interrupt line
// - Status register shows live source levels
// - Enable register masks each source alone
// - Control registers reachable from host bus only
// - Own request line, own grant line
// - Host restart accepted even when card hangs
// - Reset vector fetch remapped to low 1MB
// - BIOS addresses translated into host copy
// - Module presence sensed and latched at start
// - Drive power-on reset to card chip set
// - Forward soft-reset key code to keyboard port
// - Card bus logic runs on ref_clk, same clock as the host bus
module bridge_interrupt_reset_ctrl (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire bridge_pkg::irq_src_t irqSources,
    output logic                     hostIrq,
    output logic                     power_on_reset_out,
    input  wire logic                dimmPresent,
    output logic                     busReq_n,
    input  wire logic                busGnt_n,
    output logic      [7:0]          keyCode,
    output logic                     keyStrobe,
    input  wire bridge_pkg::card_req_t cardReq,
    output logic      [31:0]         hostAddr,
    output logic                     hostAddrValid
);

    // ==========================================================
    // Address translation helpers
    // ==========================================================
    // Top 1MB of the space folds down onto the low 1MB
    function automatic logic [31:0] remapVector(input logic [31:0] a);
        remapVector = (a[31:20] == `VEC_TOP_TAG) ? {`LOW_TAG, a[19:0]} : a;
    endfunction : remapVector

    // BIOS window, the top 128K of the low 1MB, moves onto the host-memory copy
    function automatic logic [31:0] toHost(input logic [31:0] a, input logic [31:0] base);
        toHost = (a[31:17] == `BIOS_TAG) ? base + {`BIOS_PAD, a[16:0]} : a;
    endfunction : toHost

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [`NUM_SRC-1:0] srcMeta;
    logic [`NUM_SRC-1:0] srcSync;
    logic                dimmMeta;
    logic                dimmSync;
    logic                gntMeta;
    logic                gntSync_n;

    // Two stages; the first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        srcMeta   <= irqSources;
        srcSync   <= srcMeta;
        dimmMeta  <= dimmPresent;
        dimmSync  <= dimmMeta;
        gntMeta   <= busGnt_n;
        gntSync_n <= gntMeta;
    end

    // ==========================================================
    // Register file state
    // ==========================================================
    logic [`NUM_SRC-1:0]    irqEnable;
    logic                   hardReset;
    logic [31:0]            biosBase;
    logic                   dimmLatched;
    logic [1:0]             settleCnt;
    logic                   sensePending;
    logic [7:0]             keyHold;
    bridge_pkg::mst_state_t mstState;
    bridge_pkg::mst_state_t next_mstState;

    // ==========================================================
    // APB decode
    // ==========================================================
    wire access     = psel & penable & ~pready;
    wire wrAccess   = access & pwrite;
    wire hitStatus  = paddr == `REG_STATUS;
    wire hitEnable  = paddr == `REG_ENABLE;
    wire hitReset   = paddr == `REG_RESET;
    wire hitInfo    = paddr == `REG_INFO;
    wire hitBios    = paddr == `REG_BIOS;
    wire hitKey     = paddr == `REG_KEY;
    wire mapped     = hitStatus | hitEnable | hitReset | hitInfo | hitBios | hitKey;
    wire wrEnable   = wrAccess & hitEnable;
    wire wrReset    = wrAccess & hitReset;
    wire wrBios     = wrAccess & hitBios;
    wire wrKey      = wrAccess & hitKey;
    wire mstIdle    = mstState == bridge_pkg::MST_IDLE;
    wire keyAccept  = wrKey & mstIdle & ~hardReset;
    wire hardRelease = wrReset & hardReset & ~pwdata[`HARD_RST_BIT];

    // Read mux; card side has no path to these registers
    wire [31:0] infoWord = {29'h0, ~gntSync_n, ~mstIdle, dimmLatched};
    wire [31:0] readMux  = hitStatus ? {25'h0, srcSync}
                         : hitEnable ? {25'h0, irqEnable}
                         : hitReset  ? {31'h0, hardReset}
                         : hitInfo   ? infoWord
                         : hitBios   ? biosBase
                         : hitKey    ? {24'h0, keyHold}
                         : 32'h0;

    // One wait state: answer registered on the first access edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access;
            prdata  <= access ? readMux : 32'h0;
            pslverr <= access & ~mapped;
        end
    end

    // ==========================================================
    // Control registers
    // ==========================================================
    // Hard reset bit is written at any time, even with the card hung
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqEnable <= `ENABLE_RESET;
            hardReset <= `HARD_RST_RESET;
            biosBase  <= `BIOS_RESET;
            keyHold   <= 8'h00;
        end else begin
            if (wrEnable) irqEnable <= pwdata[`NUM_SRC-1:0];
            if (wrReset)  hardReset <= pwdata[`HARD_RST_BIT];
            if (wrBios)   biosBase  <= pwdata;
            if (keyAccept) keyHold  <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Interrupt request and card reset outputs
    // ==========================================================
    // Masked pending level, shared by the request flop and its check
    wire irqPending = |(srcSync & irqEnable);

    // Level only: the source port clears it, so no sticky copy here
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hostIrq            <= 1'b0;
            power_on_reset_out <= 1'b1;
        end else begin
            hostIrq            <= irqPending;
            power_on_reset_out <= hardReset;
        end
    end

    // ==========================================================
    // Module presence sense
    // ==========================================================
    // Wait for the synchroniser to fill before trusting the pin
    always_ff @(posedge ref_clk) begin
        if (rst | hardRelease) begin
            settleCnt    <= 2'h0;
            sensePending <= 1'b1;
        end else if (sensePending) begin
            settleCnt    <= settleCnt + 2'h1;
            sensePending <= settleCnt != `DIMM_SETTLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dimmLatched <= 1'b0;
        end else if (sensePending && settleCnt == `DIMM_SETTLE) begin
            dimmLatched <= dimmSync;
        end
    end

    // ==========================================================
    // Card-bus master for key codes
    // ==========================================================
    // Hard reset drops a pending request so a stuck grant cannot hold it
    // Limitation: one key in flight; software polls the busy bit first
    always_comb begin
        next_mstState = mstState;
        unique case (mstState)
            bridge_pkg::MST_IDLE: if (keyAccept) next_mstState = bridge_pkg::MST_REQ;
            bridge_pkg::MST_REQ: begin
                if (hardReset) next_mstState = bridge_pkg::MST_IDLE;
                else if (!gntSync_n) next_mstState = bridge_pkg::MST_SEND;
            end
            bridge_pkg::MST_SEND: next_mstState = bridge_pkg::MST_IDLE;
            default: next_mstState = bridge_pkg::MST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) mstState <= bridge_pkg::MST_IDLE;
        else     mstState <= next_mstState;
    end

    wire wantBus = (next_mstState == bridge_pkg::MST_REQ) |
                   (next_mstState == bridge_pkg::MST_SEND);
    wire sendNow = (mstState == bridge_pkg::MST_REQ) &
                   (next_mstState == bridge_pkg::MST_SEND);

    // Request held from acceptance until the code has gone out
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busReq_n  <= 1'b1;
            keyCode   <= 8'h00;
            keyStrobe <= 1'b0;
        end else begin
            busReq_n  <= ~wantBus;
            keyStrobe <= sendNow;
            if (sendNow) keyCode <= keyHold;
        end
    end

    // ==========================================================
    // Card address translation
    // ==========================================================
    // Single registered stage on ref_clk
    // Remap runs before the window test so the top vector reads the BIOS copy
    wire [31:0] lowAddr = remapVector(cardReq.addr);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hostAddr      <= 32'h0;
            hostAddrValid <= 1'b0;
        end else begin
            hostAddrValid <= cardReq.valid;
            if (cardReq.valid) hostAddr <= toHost(lowAddr, biosBase);
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    irq_follows_mask_a: assert property (
        ##1 hostIrq == $past(irqPending))
        else $error("interrupt does not follow masked sources");
    irq_masked_off_a: assert property (
        (irqEnable == 7'h00) [*2] |-> !hostIrq)
        else $error("interrupt raised with all sources masked");
    status_live_a: assert property (
        access && !pwrite && hitStatus |=> prdata == {25'h0, $past(srcSync)})
        else $error("status read not live source state");
    reset_out_a: assert property (
        wrReset |=> ##1 power_on_reset_out == $past(pwdata[0], 2))
        else $error("power-on reset does not follow host bit");
    hang_restart_a: assert property (
        mstState == bridge_pkg::MST_REQ && hardReset |=> mstIdle ##1 busReq_n)
        else $error("hard reset did not drop bus request");
    grant_send_a: assert property (
        mstState == bridge_pkg::MST_REQ && !hardReset && !gntSync_n
        |=> keyStrobe && !busReq_n ##1 busReq_n)
        else $error("grant did not send key code");
    no_strobe_idle_a: assert property (
        keyStrobe |-> $past(mstState) == bridge_pkg::MST_REQ)
        else $error("key strobe without bus ownership");
    vector_remap_a: assert property (
        cardReq.valid && cardReq.addr[31:20] == 12'hfff && cardReq.addr[19:17] != 3'h7
        |=> hostAddr[31:20] == 12'h000)
        else $error("reset vector not folded to low 1MB");
    dimm_latch_a: assert property (
        $fell(sensePending) |-> dimmLatched == $past(dimmSync))
        else $error("module presence not latched");
    apb_answer_a: assert property (
        access |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

    // Refusals, the key payload and both translation branches
    unmapped_error_a: assert property (
        access && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");
    key_refused_a: assert property (
        wrKey && hardReset |=> mstIdle && busReq_n)
        else $error("key write accepted while card held in reset");
    strobe_code_a: assert property (
        keyStrobe |-> keyCode == $past(keyHold))
        else $error("key code differs from queued code");
    bios_window_a: assert property (
        cardReq.valid && cardReq.addr[31:17] == 15'h0007
        |=> hostAddr == $past(biosBase) + ($past(cardReq.addr) & 32'h0001ffff))
        else $error("BIOS window not moved onto host copy");
    passthrough_a: assert property (
        cardReq.valid && cardReq.addr[31:20] != 12'hfff && cardReq.addr[31:17] != 15'h0007
        |=> hostAddr == $past(cardReq.addr))
        else $error("address outside windows was altered");

    // ==========================================================
    // Scenario covers
    // ==========================================================

    key_sent_c:    cover property (keyAccept ##[1:20] keyStrobe);
    irq_raised_c:  cover property ($rose(hostIrq));
    bios_xlate_c:  cover property (cardReq.valid && cardReq.addr[31:17] == 15'h0007);
    restart_c:     cover property (hardRelease ##[1:10] $fell(sensePending));
    abort_c:       cover property (mstState == bridge_pkg::MST_REQ && hardReset);

endmodule : bridge_interrupt_reset_ctrl

// [testbench/card_arbiter_model.sv]
// Card-side arbiter model that answers one request line with one grant line
module card_arbiter_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       busReq_n,
    input  wire logic [3:0] grantDelay,
    output logic            busGnt_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCount;

    // ==========================================
    // Grant after a chosen delay; drop at once when the request goes away
    // Only one master is modelled, so the rotation always lands on it
    always_ff @(posedge ref_clk) begin
        if (rst || busReq_n) begin
            waitCount <= 4'h0;
            busGnt_n  <= 1'b1;
        end else if (waitCount >= grantDelay) begin
            busGnt_n  <= 1'b0;
        end else begin
            waitCount <= waitCount + 4'h1;
        end
    end
endmodule : card_arbiter_model

// [testbench/bridge_interrupt_reset_ctrl_bench.sv]
// Self-checking bench for the bridge interrupt and reset controller
`include "bridge_consts.svh"
module bridge_interrupt_reset_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdData, hostAddr;
    logic        pready, pslverr, rdErr, hostIrq, power_on_reset_out, dimmPresent = 1'b1;
    logic        busReq_n, busGnt_n, keyStrobe, hostAddrValid;
    logic [7:0]  keyCode;
    logic [3:0]  grantDelay = 4'h1;
    bridge_pkg::irq_src_t  irqSources = 7'h00;
    bridge_pkg::card_req_t cardReq = 33'h0;
    int bad_count = 0, n_checks = 0, cycles = 0;

    always #2 ref_clk = ~ref_clk;

    bridge_interrupt_reset_ctrl bridge_interrupt_reset_ctrl_i (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irqSources(irqSources), .hostIrq(hostIrq),
        .power_on_reset_out(power_on_reset_out), .dimmPresent(dimmPresent),
        .busReq_n(busReq_n), .busGnt_n(busGnt_n), .keyCode(keyCode),
        .keyStrobe(keyStrobe), .cardReq(cardReq), .hostAddr(hostAddr),
        .hostAddrValid(hostAddrValid));
    card_arbiter_model card_arbiter_model_i (
        .ref_clk(ref_clk), .rst(rst), .busReq_n(busReq_n),
        .grantDelay(grantDelay), .busGnt_n(busGnt_n));

    // ==========================================
    // Verdict, reached from the main sequence or the hang limit
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count = bad_count + 1;
            close_out();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ==========================================
    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Reset values and the unmapped hole
    task automatic test_reset_map();
        chk(power_on_reset_out, 1'b1);
        apb(1'b0, `REG_RESET, 32'h0); chk(rdData, 32'h1);
        apb(1'b0, `REG_ENABLE, 32'h0); chk(rdData, 32'h0);
        apb(1'b0, `REG_BIOS, 32'h0); chk(rdData, `BIOS_RESET);
        apb(1'b0, 8'h18, 32'h0); chk({rdData, 31'h0, rdErr}, {32'h0, 32'h1});
        apb(1'b0, `REG_INFO, 32'h0); chk(rdData, 32'h1);
    endtask : test_reset_map

    // Key write goes out once when expectSend is set; with the card held in reset it must not reach the keyboard port
    task automatic test_key(input logic [7:0] code, input logic expectSend);
        int seen;
        seen = 0;
        apb(1'b1, `REG_KEY, {24'h0, code});
        repeat (30) begin
            @(posedge ref_clk);
            if (keyStrobe === 1'b1) begin
                seen = seen + 1;
                chk({busReq_n, keyCode}, {1'b0, code});
            end
        end
        chk(seen, expectSend);
        chk(busReq_n, 1'b1);
    endtask : test_key

    // Live status, per-source mask and the interrupt line
    task automatic test_irq();
        irqSources <= 7'h44;
        repeat (5) @(posedge ref_clk);
        apb(1'b0, `REG_STATUS, 32'h0); chk(rdData, 32'h44);
        chk(hostIrq, 1'b0);
        apb(1'b1, `REG_ENABLE, 32'h3b); repeat (3) @(posedge ref_clk);
        chk(hostIrq, 1'b0);
        apb(1'b1, `REG_ENABLE, 32'h04); repeat (3) @(posedge ref_clk);
        chk(hostIrq, 1'b1);
        irqSources <= 7'h40; repeat (5) @(posedge ref_clk);
        chk(hostIrq, 1'b0);
        apb(1'b0, `REG_STATUS, 32'h0); chk(rdData, 32'h40);
    endtask : test_irq

    // Host writes hard reset; presence is re-latched only on a release
    task automatic test_hard_reset(input logic [31:0] val, input logic pin, input logic expDimm);
        dimmPresent <= pin;
        apb(1'b1, `REG_RESET, val); repeat (8) @(posedge ref_clk);
        chk(power_on_reset_out, val[0]);
        apb(1'b0, `REG_INFO, 32'h0); chk(rdData[0], expDimm);
    endtask : test_hard_reset

    // Hard reset while the request waits for a grant drops it with no strobe
    task automatic test_key_abort(input logic [7:0] code);
        int seen;
        seen = 0;
        grantDelay <= 4'hf;
        apb(1'b1, `REG_KEY, {24'h0, code});
        apb(1'b0, `REG_INFO, 32'h0); chk(rdData, 32'h2);
        apb(1'b1, `REG_RESET, 32'h1);
        repeat (30) begin
            @(posedge ref_clk);
            if (keyStrobe === 1'b1) seen = seen + 1;
        end
        chk(seen, 0);
        chk({busReq_n, power_on_reset_out}, 2'h3);
    endtask : test_key_abort

    // Reset-vector remap, BIOS window translation and passthrough, back to back
    task automatic test_translate();
        logic [31:0] addrs [4] = '{32'hfffffff0, 32'hfff12345, 32'h000e1234, 32'h00123456};
        logic [31:0] exps [4] = '{32'h1235fff0, 32'h00012345, 32'h12341234, 32'h00123456};
        apb(1'b1, `REG_BIOS, 32'h12340000);
        // Result of the request driven two edges back is visible here
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            cardReq <= (i < 4) ? {1'b1, addrs[i]} : 33'h0;
            if (i > 1) chk({hostAddrValid, hostAddr}, {1'b1, exps[i-2]});
        end
        @(posedge ref_clk);
        chk({hostAddrValid, hostAddr}, {1'b0, exps[3]});
    endtask : test_translate

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset_map();
        test_key(8'h5a, 1'b0);
        test_irq();
        test_hard_reset(32'h0, 1'b0, 1'b0);
        test_key(8'ha5, 1'b1);
        grantDelay <= 4'h9;
        test_key(8'h3c, 1'b1);
        test_translate();
        test_key_abort(8'h96);
        test_hard_reset(32'h1, 1'b1, 1'b0);
        close_out();
    end
endmodule : bridge_interrupt_reset_ctrl_bench
